// >>> rtl/mba_arbiter.sv
// requestor-side access arbiter for the shared memory backplane bus
// assumes all pins synchronous to SYS_CLK, a classic wishbone master,
// and peers that keep their own arbitration wire and busy lines
// ==========================================
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "mba_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mba_arbiter #(
    parameter int ID_W  = 3,
    parameter int ARB_N = 8
) (
    input  wire  logic             SYS_CLK,
    input  wire  logic             NRST,
    input  wire  logic             CE,
    input  wire  logic             CYC_I,
    input  wire  logic             STB_I,
    input  wire  logic             WE_I,
    input  wire  logic [7:0]       ADR_I,
    input  wire  logic [3:0]       SEL_I,
    input  wire  logic [31:0]      DAT_I,
    output logic       [31:0]      DAT_O,
    output logic                   ACK_O,
    input  wire  logic [3:0]       CARD_TYPE_ONEHOT,
    input  wire  logic [3:0]       ONLINE_CARD_COUNT,
    input  wire  logic [15:0]      CARD_BUSY_LINES,
    input  wire  logic [1:0]       IO_CONC_BUSY_N,
    input  wire  logic [4:0]       REMOTE_SELECT_IN,
    input  wire  logic [ARB_N-1:0] ARB_REQUEST_IN,
    input  wire  logic             BUS_PHASE_LEVEL,
    input  wire  logic             BUS_VALID_IN,
    input  wire  logic [4:0]       BUS_MODSEL_IN,
    input  wire  logic [ID_W-1:0]  BUS_ID_IN,
    input  wire  logic [ID_W-1:0]  JUMPER_ID,
    output logic       [ARB_N-1:0] ARB_REQUEST_OUT,
    output logic       [4:0]       LOCAL_SELECT_COPY,
    output logic                   BUS_DRIVE,
    output logic       [26:0]      BUS_ADDR_OUT,
    output logic       [1:0]       BUS_CMD_OUT,
    output logic       [ID_W-1:0]  BUS_ID_OUT,
    output logic                   BROKEN,
    output logic                   CFG_ERR
);

    // ==========================================
    // elaboration checks
    if (ARB_N != (1 << ID_W)) begin : g_bad_width
        $error("ARB_N must equal 2**ID_W");
    end
    if (ARB_N > 32) begin : g_bad_count
        $error("ARB_N above 32 not served");
    end

    // ==========================================
    // declarations
    mba_pkg::mba_state_t state;
    mba_pkg::mba_cmd_t   cmd;
    logic [4:0]          target;
    logic [26:0]         addr;
    logic                phase_q;
    logic                ph_end;
    logic [24:0]         hist [`MBA_HIST_CYC];
    logic [24:0]         sel_now;
    logic [24:0]         hist_busy;
    logic [24:0]         busy_vec;
    logic                target_ok;
    logic                io_tgt;
    logic                higher_req;
    logic [ARB_N-1:0]    arb_q;
    logic                arb_q_valid;
    logic [ID_W-1:0]     expect_id;
    logic                done;
    logic                reject;
    logic                go;
    logic                go_ok;
    logic                wr_ctrl;
    logic                wr_addr;
    logic                wr_stat;
    logic [31:0]         wmask;
    logic [31:0]         rdata;
    logic                bus_req;
    logic [2:0]          n4way;
    logic                has2;
    logic                has1;
    logic [4:0]          card_total;
    logic [1:0]          size_code;
    logic [4:0]          next_target;
    mba_pkg::mba_cmd_t   next_cmd;

    // ==========================================
    // phase level and bus cycle boundary
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            phase_q <= 1'b0;
        end else if (CE) begin
            phase_q <= BUS_PHASE_LEVEL;
        end
    end

    // the registered level marks the second clock of each bus cycle
    assign ph_end = phase_q;

    // ==========================================
    // selected module history
    function automatic logic [24:0] mod_bit(input logic [4:0] m);
        logic [24:0] v;
        v = 25'h0;
        if (m >= `MBA_IO_FIRST) begin
            v[`MBA_IO_BIT] = 1'b1;
        end else begin
            v[m] = 1'b1;
        end
        return v;
    endfunction : mod_bit

    always_comb begin
        sel_now = 25'h0;
        if (BUS_VALID_IN) begin
            sel_now = mod_bit(BUS_MODSEL_IN);
        end
        if (REMOTE_SELECT_IN != 5'h0) begin
            sel_now = sel_now | mod_bit(REMOTE_SELECT_IN);
        end
    end

    // one entry per remembered bus cycle
    genvar gi;
    generate
        for (gi = 0; gi < `MBA_HIST_CYC; gi++) begin : g_hist
            always_ff @(posedge SYS_CLK or negedge NRST) begin
                if (!NRST) begin
                    hist[gi] <= 25'h0;
                end else if (CE && ph_end) begin
                    if (gi == 0) begin
                        hist[gi] <= sel_now;
                    end else begin
                        hist[gi] <= hist[(gi == 0) ? 0 : gi - 1];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        hist_busy = 25'h0;
        for (int i = 0; i < `MBA_HIST_CYC; i++) begin
            hist_busy = hist_busy | hist[i];
        end
    end

    always_comb begin
        busy_vec = hist_busy;
        busy_vec[`MBA_CARDS-1:0] = hist_busy[`MBA_CARDS-1:0]
                                 | CARD_BUSY_LINES;
        // only both concentrators busy blocks io traffic
        busy_vec[`MBA_IO_BIT] = hist_busy[`MBA_IO_BIT]
                              | ~(|IO_CONC_BUSY_N);
    end

    assign io_tgt    = (target >= `MBA_IO_FIRST);
    assign target_ok = !busy_vec[io_tgt ? 5'(`MBA_IO_BIT) : target];

    // ==========================================
    // arbitration
    always_comb begin
        higher_req = 1'b0;
        for (int i = 0; i < ARB_N; i++) begin
            if (i > int'(JUMPER_ID) && ARB_REQUEST_IN[i]) begin
                higher_req = 1'b1;
            end
        end
    end

    always_comb begin
        expect_id = '0;
        for (int i = 0; i < ARB_N; i++) begin
            if (arb_q[i]) begin
                expect_id = ID_W'(i);
            end
        end
    end

    // wires are sampled on the second clock of the cycle so that
    // far-cabinet signals have a full clock to cross the backplane
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            arb_q       <= '0;
            arb_q_valid <= 1'b0;
        end else if (CE && ph_end) begin
            arb_q       <= ARB_REQUEST_IN;
            arb_q_valid <= |ARB_REQUEST_IN;
        end
    end

    // ==========================================
    // register bus decode
    assign bus_req = CYC_I && STB_I && !ACK_O;
    // a write lands at the edge at which the master samples ack high
    assign wr_ctrl = CYC_I && STB_I && ACK_O && WE_I && ADR_I == `MBA_OFS_CTRL;
    assign wr_addr = CYC_I && STB_I && ACK_O && WE_I && ADR_I == `MBA_OFS_ADDR;
    assign wr_stat = CYC_I && STB_I && ACK_O && WE_I && ADR_I == `MBA_OFS_STATUS;
    assign wmask   = {{8{SEL_I[3]}}, {8{SEL_I[2]}},
                      {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    assign go      = wr_ctrl && SEL_I[3] && DAT_I[`MBA_CTRL_GO_BIT];

    // the go check must see the target and command written with it
    always_comb begin
        next_target = target;
        next_cmd    = cmd;
        if (SEL_I[0]) begin
            next_target = DAT_I[`MBA_CTRL_MOD_LSB +: 5];
        end
        if (SEL_I[1]) begin
            next_cmd = mba_pkg::mba_cmd_t'(DAT_I[`MBA_CTRL_CMD_LSB +: 2]);
        end
    end

    // io targets take only io commands and memory targets only block
    // commands; modules 16..23 do not exist on this bus
    always_comb begin
        go_ok = 1'b1;
        if (next_target >= `MBA_IO_FIRST) begin
            go_ok = (next_cmd == mba_pkg::MBA_CMD_IO_RD)
                 || (next_cmd == mba_pkg::MBA_CMD_IO_WR);
        end else if (next_target >= 5'(`MBA_CARDS)) begin
            go_ok = 1'b0;
        end else begin
            go_ok = (next_cmd == mba_pkg::MBA_CMD_RD_BLOCK)
                 || (next_cmd == mba_pkg::MBA_CMD_WR_BLOCK);
        end
    end

    // ==========================================
    // request parameters
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            target <= 5'h0;
            cmd    <= mba_pkg::MBA_CMD_RD_BLOCK;
        end else if (CE && wr_ctrl && state == mba_pkg::MBA_ST_IDLE) begin
            target <= next_target;
            cmd    <= next_cmd;
        end
    end

    // address field also selects the io information kind
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            addr <= `MBA_RST_ADDR;
        end else if (CE && wr_addr && state == mba_pkg::MBA_ST_IDLE) begin
            addr <= (addr & ~wmask[26:0]) | (DAT_I[26:0] & wmask[26:0]);
        end
    end

    // ==========================================
    // requestor sequencing
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state <= mba_pkg::MBA_ST_IDLE;
        end else if (CE) begin
            case (state)
                mba_pkg::MBA_ST_IDLE: begin
                    if (go && go_ok) begin
                        state <= mba_pkg::MBA_ST_WAIT;
                    end
                end
                mba_pkg::MBA_ST_WAIT: begin
                    if (ph_end && target_ok) begin
                        state <= mba_pkg::MBA_ST_ARB;
                    end
                end
                mba_pkg::MBA_ST_ARB: begin
                    if (!target_ok) begin
                        state <= mba_pkg::MBA_ST_WAIT;
                    end else if (ph_end && !higher_req) begin
                        state <= mba_pkg::MBA_ST_OWN;
                    end
                end
                mba_pkg::MBA_ST_OWN: begin
                    if (ph_end) begin
                        state <= mba_pkg::MBA_ST_IDLE;
                    end
                end
                default: begin
                    state <= mba_pkg::MBA_ST_IDLE;
                end
            endcase
        end
    end

    // only our jumper wire is ever driven; dropped once we own the bus
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ARB_REQUEST_OUT <= '0;
        end else if (CE) begin
            ARB_REQUEST_OUT <= '0;
            if ((state == mba_pkg::MBA_ST_WAIT && ph_end && target_ok)
                || (state == mba_pkg::MBA_ST_ARB && target_ok
                    && !(ph_end && !higher_req))) begin
                ARB_REQUEST_OUT[JUMPER_ID] <= 1'b1;
            end
        end
    end

    // ==========================================
    // backplane drive while owning the bus
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            BUS_DRIVE         <= 1'b0;
            BUS_ADDR_OUT      <= `MBA_RST_ADDR;
            BUS_CMD_OUT       <= 2'h0;
            BUS_ID_OUT        <= '0;
            LOCAL_SELECT_COPY <= 5'h0;
        end else if (CE) begin
            if (state == mba_pkg::MBA_ST_ARB && target_ok
                && ph_end && !higher_req) begin
                BUS_DRIVE         <= 1'b1;
                BUS_ADDR_OUT      <= addr;
                BUS_CMD_OUT       <= cmd;
                BUS_ID_OUT        <= JUMPER_ID;
                LOCAL_SELECT_COPY <= target;
            end else if (state == mba_pkg::MBA_ST_OWN && ph_end) begin
                BUS_DRIVE         <= 1'b0;
                LOCAL_SELECT_COPY <= 5'h0;
            end
        end
    end

    // ==========================================
    // sticky flags; a hardware set wins over a software clear
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            BROKEN <= 1'b0;
        end else if (CE) begin
            if (ph_end && BUS_VALID_IN && arb_q_valid
                && BUS_ID_IN != expect_id) begin
                BROKEN <= 1'b1;
            end else if (wr_stat && SEL_I[0]
                         && DAT_I[`MBA_ST_BROKEN]) begin
                BROKEN <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            done <= 1'b0;
        end else if (CE) begin
            if (state == mba_pkg::MBA_ST_OWN && ph_end) begin
                done <= 1'b1;
            end else if (wr_stat && SEL_I[0] && DAT_I[`MBA_ST_DONE]) begin
                done <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            reject <= 1'b0;
        end else if (CE) begin
            if (go && (!go_ok || state != mba_pkg::MBA_ST_IDLE)) begin
                reject <= 1'b1;
            end else if (wr_stat && SEL_I[0] && DAT_I[`MBA_ST_REJECT]) begin
                reject <= 1'b0;
            end
        end
    end

    // ==========================================
    // configuration decode
    // a zero count stands for sixteen cards, the field being four bits
    assign card_total = (ONLINE_CARD_COUNT == 4'h0) ? 5'h10
                      : {1'b0, ONLINE_CARD_COUNT};
    assign n4way      = card_total[4:2];
    assign has2       = card_total[1];
    assign has1       = card_total[0];

    // a single type present is what the cards report; any other pattern gives code 0
    always_comb begin
        size_code = 2'h0;
        case (CARD_TYPE_ONEHOT)
            4'h8:    size_code = 2'h3;
            4'h4:    size_code = 2'h2;
            4'h2:    size_code = 2'h1;
            default: size_code = 2'h0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            CFG_ERR <= 1'b0;
        end else if (CE) begin
            CFG_ERR <= !$onehot(CARD_TYPE_ONEHOT);
        end
    end

    // ==========================================
    // read mux; unmapped offsets read zero
    always_comb begin
        rdata = 32'h0;
        case (ADR_I)
            `MBA_OFS_CTRL: begin
                rdata[`MBA_CTRL_MOD_LSB +: 5] = target;
                rdata[`MBA_CTRL_CMD_LSB +: 2] = cmd;
            end
            `MBA_OFS_ADDR: begin
                rdata[26:0] = addr;
            end
            `MBA_OFS_STATUS: begin
                rdata[`MBA_ST_BUSY]   = state != mba_pkg::MBA_ST_IDLE;
                rdata[`MBA_ST_DONE]   = done;
                rdata[`MBA_ST_BROKEN] = BROKEN;
                rdata[`MBA_ST_CFGERR] = CFG_ERR;
                rdata[`MBA_ST_REJECT] = reject;
                rdata[`MBA_ST_OWN]    = state == mba_pkg::MBA_ST_OWN;
            end
            `MBA_OFS_BUSYMAP: begin
                rdata[24:0] = busy_vec;
            end
            `MBA_OFS_CONFIG: begin
                rdata[3:0]   = CARD_TYPE_ONEHOT;
                rdata[5:4]   = size_code;
                rdata[10:8]  = n4way;
                rdata[12]    = has2;
                rdata[13]    = has1;
                rdata[20:16] = card_total;
            end
            `MBA_OFS_IDENT: begin
                rdata[ID_W-1:0] = JUMPER_ID;
            end
            default: begin
                rdata = 32'h0;
            end
        endcase
    end

    // every access, mapped or not, is acked one clock after the strobe
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0;
        end else if (CE) begin
            ACK_O <= bus_req;
            if (bus_req && !WE_I) begin
                DAT_O <= rdata;
            end
        end
    end

endmodule : mba_arbiter

`default_nettype wire

// >>> rtl/mba_defs.svh
// register offsets, field positions, reset values and timing counts
// for the memory bus access arbiter; included by the arbiter only
`ifndef MBA_DEFS_SVH
`define MBA_DEFS_SVH
// ==========================================
// register byte offsets
`define MBA_OFS_CTRL    8'h00
`define MBA_OFS_ADDR    8'h04
`define MBA_OFS_STATUS  8'h08
`define MBA_OFS_BUSYMAP 8'h0c
`define MBA_OFS_CONFIG  8'h10
`define MBA_OFS_IDENT   8'h14
// ==========================================
// control register fields
`define MBA_CTRL_MOD_LSB 0
`define MBA_CTRL_CMD_LSB 8
`define MBA_CTRL_GO_BIT  31
// ==========================================
// status register fields
`define MBA_ST_BUSY   0
`define MBA_ST_DONE   1
`define MBA_ST_BROKEN 2
`define MBA_ST_CFGERR 3
`define MBA_ST_REJECT 4
`define MBA_ST_OWN    5
// ==========================================
// module numbering and timing
`define MBA_IO_FIRST   5'h18
`define MBA_IO_BIT     24
`define MBA_CARDS      16
`define MBA_HIST_CYC   2
`define MBA_BUS_CLKS   2
`define MBA_RST_ADDR   27'h0
`endif

// >>> rtl/mba_pkg.sv
// types shared by the memory bus access arbiter
// assumes nothing beyond a SystemVerilog compiler
package mba_pkg;
    // ==========================================
    // bus commands
    typedef enum logic [1:0] {
        MBA_CMD_RD_BLOCK,
        MBA_CMD_WR_BLOCK,
        MBA_CMD_IO_RD,
        MBA_CMD_IO_WR
    } mba_cmd_t;
    // ==========================================
    // requestor sequencing
    typedef enum logic [1:0] {
        MBA_ST_IDLE,
        MBA_ST_WAIT,
        MBA_ST_ARB,
        MBA_ST_OWN
    } mba_state_t;
endpackage : mba_pkg

// >>> verification/mba_arbiter_props.sv
// port checks for the memory bus access arbiter, bound into it
// assumes CE is held high, so every clock edge is an active one
`timescale 1ns/1ps
`default_nettype none
module mba_arbiter_props #(
    parameter int ID_W  = 3,
    parameter int ARB_N = 8
) (
    input wire logic             SYS_CLK,
    input wire logic             NRST,
    input wire logic             ACK_O,
    input wire logic [3:0]       CARD_TYPE_ONEHOT,
    input wire logic [ARB_N-1:0] ARB_REQUEST_IN,
    input wire logic [ID_W-1:0]  JUMPER_ID,
    input wire logic [ARB_N-1:0] ARB_REQUEST_OUT,
    input wire logic [4:0]       LOCAL_SELECT_COPY,
    input wire logic             BUS_DRIVE,
    input wire logic [1:0]       BUS_CMD_OUT,
    input wire logic [ID_W-1:0]  BUS_ID_OUT,
    input wire logic             CFG_ERR
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    logic [ARB_N-1:0] own;
    assign own = ARB_N'(1) << JUMPER_ID;
    // ==========================================
    // properties
    sequence s_two;
        BUS_DRIVE ##1 !BUS_DRIVE;
    endsequence
    property p_bus_cycle; $rose(BUS_DRIVE) |=> s_two; endproperty
    a_bus_cycle: assert property (p_bus_cycle) else $error("drive length");
    property p_own_wire; (ARB_REQUEST_OUT & ~own) == '0; endproperty
    a_own_wire: assert property (p_own_wire) else $error("foreign wire");
    property p_sel_idle; !BUS_DRIVE |-> LOCAL_SELECT_COPY == 5'h00; endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("select while idle");
    property p_ack; ACK_O |=> !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack too long");
    property p_cfg; $past(NRST) |-> CFG_ERR == !$onehot($past(CARD_TYPE_ONEHOT)); endproperty
    a_cfg: assert property (p_cfg) else $error("config error flag");
    property p_drop; $rose(BUS_DRIVE) |-> ARB_REQUEST_OUT == '0 && $past(ARB_REQUEST_OUT) == own; endproperty
    a_drop: assert property (p_drop) else $error("wire at grant");
    property p_top; $rose(BUS_DRIVE) |-> ($past(ARB_REQUEST_IN) >> JUMPER_ID) == ARB_N'(1); endproperty
    a_top: assert property (p_top) else $error("grant under higher");
    property p_id; BUS_DRIVE |-> BUS_ID_OUT == JUMPER_ID; endproperty
    a_id: assert property (p_id) else $error("bus id");
    property p_io; BUS_DRIVE |-> (LOCAL_SELECT_COPY >= 5'h18) == BUS_CMD_OUT[1]; endproperty
    a_io: assert property (p_io) else $error("io command");
endmodule : mba_arbiter_props
bind mba_arbiter mba_arbiter_props #(.ID_W(ID_W), .ARB_N(ARB_N)) u_props (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .ACK_O(ACK_O), .CARD_TYPE_ONEHOT(CARD_TYPE_ONEHOT), .ARB_REQUEST_IN(ARB_REQUEST_IN), .JUMPER_ID(JUMPER_ID),
    .ARB_REQUEST_OUT(ARB_REQUEST_OUT), .LOCAL_SELECT_COPY(LOCAL_SELECT_COPY), .BUS_DRIVE(BUS_DRIVE),
    .BUS_CMD_OUT(BUS_CMD_OUT), .BUS_ID_OUT(BUS_ID_OUT), .CFG_ERR(CFG_ERR));
`default_nettype wire

// >>> verification/mba_arbiter_test.sv
// self-checking bench for the memory bus access arbiter
// assumes the backplane model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module mba_arbiter_test;
    logic        clk, rst_n, cyc, stb, we, ack, drive, broken, cfg_err, bad, phase, valid;
    logic [7:0]  adr, arb_out, arb_in, peer;
    logic [31:0] dat_w, dat_r, rdat, exp;
    logic [3:0]  ctype, ccount;
    logic [15:0] cbusy;
    logic [1:0]  io_n, bcmd;
    logic [4:0]  rsel, lsel, modsel;
    logic [2:0]  bid, id_seen;
    logic [26:0] baddr;
    int          bad_count = 0, n_compared = 0, cycles = 0;
    logic [4:0]  m_sel [4] = '{5'h09, 5'h19, 5'h1a, 5'h15};
    logic [1:0]  m_cmd [4] = '{2'h2, 2'h0, 2'h0, 2'h0};
    mba_arbiter dut (.SYS_CLK(clk), .NRST(rst_n), .CE(1'b1), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hf), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .CARD_TYPE_ONEHOT(ctype),
        .ONLINE_CARD_COUNT(ccount), .CARD_BUSY_LINES(cbusy), .IO_CONC_BUSY_N(io_n), .REMOTE_SELECT_IN(rsel),
        .ARB_REQUEST_IN(arb_in), .BUS_PHASE_LEVEL(phase), .BUS_VALID_IN(valid), .BUS_MODSEL_IN(modsel),
        .BUS_ID_IN(id_seen), .JUMPER_ID(3'h3), .ARB_REQUEST_OUT(arb_out), .LOCAL_SELECT_COPY(lsel),
        .BUS_DRIVE(drive), .BUS_ADDR_OUT(baddr), .BUS_CMD_OUT(bcmd), .BUS_ID_OUT(bid), .BROKEN(broken),
        .CFG_ERR(cfg_err));
    mba_backplane_model u_bp (.clk(clk), .rst_n(rst_n), .drive(drive), .sel_out(lsel), .id_out(bid),
        .arb_out(arb_out), .peer_req(peer), .bad_id(bad), .phase(phase), .valid(valid), .modsel(modsel),
        .id_seen(id_seen), .arb_in(arb_in));
    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_r;
        cyc  <= 1'b0;
        stb  <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic go(input logic [4:0] m, input logic [1:0] c);
        wb(1'b1, 8'h04, 32'h0123abc);
        wb(1'b1, 8'h00, {1'b1, 21'h0, c, 3'h0, m});
    endtask : go
    task automatic wait_drive;
        int n;
        n = 0;
        while (drive !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_drive
    task automatic granted(input logic [4:0] m, input logic [1:0] c);
        wait_drive();
        chk(32'(drive), 32'h1, "drive");
        chk(32'(lsel), 32'(m), "select copy");
        chk(32'(bcmd), 32'(c), "command");
        chk(32'(bid), 32'h3, "bus id");
        chk(32'(baddr), 32'h0123abc, "bus addr");
        do rd(8'h08); while (rdat[0] !== 1'b0);
    endtask : granted
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // ==========================================
    // clock, timeout and tests
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        {cyc, stb, we, adr, dat_w, rsel, peer, bad, cbusy, rst_n} = '0;
        ctype = 4'h8;
        ccount = 4'h0;
        io_n = 2'b11;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int n = 1; n <= 16; n++) begin
            ctype  <= 4'(1 << (n % 4));
            ccount <= 4'(n);
            repeat (2) @(posedge clk);
            rd(8'h10);
            exp = 32'(n << 16 | (n & 1) << 13 | (n & 2) << 11 | (n >> 2) << 8 | (n % 4) << 4 | 1 << (n % 4));
            chk(rdat, exp, "config");
        end
        ctype <= 4'h5;
        repeat (3) @(posedge clk);
        chk(32'(cfg_err), 32'h1, "cfg_err");
        ctype <= 4'h1;
        rd(8'h14);
        chk(rdat, 32'h3, "ident");
        rd(8'h20);
        chk(rdat, 32'h0, "unmapped");
        $display("done config");
        go(5'h05, 2'h0);
        granted(5'h05, 2'h0);
        rd(8'h08);
        chk(32'(rdat[1]), 32'h1, "done");
        cbusy <= 16'h0020;
        go(5'h05, 2'h1);
        repeat (30) @(posedge clk);
        chk(32'(arb_out), 32'h0, "wire on busy card");
        cbusy <= 16'h0;
        granted(5'h05, 2'h1);
        peer <= 8'h81;
        go(5'h02, 2'h0);
        repeat (30) @(posedge clk);
        chk(32'(arb_out), 32'h08, "own wire");
        chk(32'(drive), 32'h0, "drive under higher");
        peer <= 8'h01;
        granted(5'h02, 2'h0);
        peer <= 8'h00;
        $display("done arbitration");
        for (int i = 0; i < 2; i++) begin
            rsel <= m_sel[i];
            repeat (2) @(posedge clk);
            rsel <= 5'h00;
            rd(8'h0c);
            chk(32'(rdat[i ? 24 : 9]), 32'h1, "busy map set");
            repeat (8) @(posedge clk);
            rd(8'h0c);
            chk(rdat, 32'h0, "busy map clear");
        end
        io_n <= 2'b00; // both concentrators refuse; the request must wait
        go(5'h1a, 2'h3);
        repeat (20) @(posedge clk);
        chk(32'(drive), 32'h0, "io while busy");
        io_n <= 2'b10;
        granted(5'h1a, 2'h3);
        io_n <= 2'b11;
        $display("done busy");
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h08, 32'h16);
            go(m_sel[i] + 5'(i == 0 ? 5'h1c : 5'h0), m_cmd[i]);
            rd(8'h08);
            chk(32'(rdat[4:0]), 32'h10, "reject");
        end
        bad <= 1'b1;
        go(5'h07, 2'h0);
        wait_drive();
        repeat (6) @(posedge clk);
        chk(32'(broken), 32'h1, "broken");
        $display("done refusals");
        wrap_up();
    end
endmodule : mba_arbiter_test
`default_nettype wire

// >>> verification/mba_backplane_model.sv
// backplane model: phase source, module select and id echo, peer arbitration wires
// assumes one requestor under test; peers only raise their wires
`timescale 1ns/1ps
`default_nettype none
module mba_backplane_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       drive,
    input  wire logic [4:0] sel_out,
    input  wire logic [2:0] id_out,
    input  wire logic [7:0] arb_out,
    input  wire logic [7:0] peer_req,
    input  wire logic       bad_id,
    output logic            phase,
    output logic            valid,
    output logic      [4:0] modsel,
    output logic      [2:0] id_seen,
    output logic      [7:0] arb_in
);
    // ==========================================
    // phase level: high on the opening clock of each bus cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end
    // ==========================================
    // a released bus shows a toggling pattern, never the last value
    assign valid   = drive;
    assign modsel  = drive ? sel_out : {5{phase}};
    assign id_seen = drive ? (bad_id ? ~id_out : id_out) : {3{phase}};
    assign arb_in  = arb_out | peer_req;
endmodule : mba_backplane_model
`default_nettype wire
